// ---- common/lps_pkg.sv ----
// Package for the low-power state controller: states, timing and grouped signals.
package lps_pkg;

   // ==========================================================================
   // Timing.
   localparam int          CLK_PERIOD_PS     = 5000;
   localparam int          BCLK_PERIOD_PS    = 10000;
   localparam int          STOP_CLOCK_REQUEST_EXIT_BCLKS = 10;
   localparam int          SLEEP_ENTER_BCLKS = 10;
   localparam int          SLEEP_EXIT_BCLKS  = 10;
   // Longest times round down, never below one cycle.
   localparam int          STOP_CLOCK_REQUEST_EXIT_CYC   = (STOP_CLOCK_REQUEST_EXIT_BCLKS * BCLK_PERIOD_PS / CLK_PERIOD_PS < 1)
                                               ? 1 : STOP_CLOCK_REQUEST_EXIT_BCLKS * BCLK_PERIOD_PS / CLK_PERIOD_PS;
   localparam int          SLEEP_ENTER_CYC   = (SLEEP_ENTER_BCLKS * BCLK_PERIOD_PS / CLK_PERIOD_PS < 1)
                                               ? 1 : SLEEP_ENTER_BCLKS * BCLK_PERIOD_PS / CLK_PERIOD_PS;
   localparam int          SLEEP_EXIT_CYC    = (SLEEP_EXIT_BCLKS * BCLK_PERIOD_PS / CLK_PERIOD_PS < 1)
                                               ? 1 : SLEEP_EXIT_BCLKS * BCLK_PERIOD_PS / CLK_PERIOD_PS;
   localparam int          CNT_W             = 6;

   // ==========================================================================
   // Clock-stop control register bit and reset value.
   localparam logic [11:0] CLKSTOP_MSR_ADDR  = 12'h02A;
   localparam int          CLKSTOP_BIT       = 26;
   localparam logic        CLKSTOP_RST       = 1'b0;

   // ==========================================================================
   // Special bus cycle codes driven on the byte enables.
   localparam logic [7:0]  BE_IDLE           = 8'h00;
   localparam logic [7:0]  BE_HALT           = 8'h02;
   localparam logic [7:0]  BE_STOP_GRANT     = 8'h04;
   localparam logic [4:0]  REQ_SPECIAL       = 5'h08;
   localparam logic [4:0]  REQ_IDLE          = 5'h00;

   // ==========================================================================
   // Power states, one-hot.
   typedef enum logic [7:0] {
      ST_NORMAL   = 8'h01,
      ST_HALT     = 8'h02,
      ST_GRANT    = 8'h04,
      ST_SNOOP    = 8'h08,
      ST_SLP_IN   = 8'h10,
      ST_SLEEP    = 8'h20,
      ST_SLP_OUT  = 8'h40,
      ST_RESUME   = 8'h80
   } lps_state_t;

   // Interrupt-like events from the pins, all active high here.
   typedef struct packed {
      logic smi;
      logic bus_init;
      logic warm_init;
      logic [1:0] lint;
   } lps_evt_t;

   // Special bus cycle request towards the bus unit.
   typedef struct packed {
      logic       valid;
      logic [7:0] byte_enables;
      logic [4:0] req;
   } lps_cycle_t;

endpackage : lps_pkg

// ---- core/lps_ctrl.sv ----
// Processor low-power state controller: halt, stop-grant, snoop and sleep.
// What this block and the system must do
// RQ1 - Core clocks fully stop in grant and sleep only when control bit 26 set.
// RQ2 - System never keeps one processor asleep while another runs or is granted.
// RQ3 - Halt instruction enters auto halt and issues a halt special cycle.
// RQ4 - Management interrupt, bus init, warm restart or local pins leave halt; reset reinitializes.
// RQ5 - Management interrupt from halt runs handler; return may go to normal or halt. Code: return never re-enters halt.
// RQ6 - Cache purge in halt flushes both cache levels then goes back to halt.
// RQ7 - Address bit 20 mask in halt applies before cache lookup and bus access.
// RQ8 - Stop request in halt gives grant cycle; release resumes halt without new cycle.
// RQ9 - Stop request enters grant with a grant cycle; release exits within ten bus clocks.
// RQ10 - In grant, system leaves open-drain pins undriven and other inputs inactive.
// RQ11 - In grant, bus init is latched for later; cache purge is not serviced.
// RQ12 - Reset in grant reinitializes but stays in grant until stop request released.
// RQ13 - Other interrupts in grant are latched and serviced after return to normal.
// RQ14 - Address strobe in grant or halt enters snoop until serviced, then returns.
// RQ15 - Sleep request only from grant, 100 bus clocks after grant cycle completes.
// RQ16 - Sleep reached ten bus clocks after request; context kept; exit within ten.
// RQ17 - Sleep request is ignored in normal and auto halt.
// RQ18 - System blocks bus traffic and holds inputs still across sleep transitions.
// RQ19 - System wakes the sleeping device for snoops and interrupts by releasing requests.
// RQ20 - Reset held in sleep resets directly, skipping grant.
// RQ21 - Interrupt-controller clock runs in halt and grant; may stop only in sleep.
// RQ22 - No low-power entry until cache queues empty; cache requests resume on return.
`timescale 1ns/1ps
`default_nettype none

module lps_ctrl #(
   parameter int STP_EXIT_CYC  = lps_pkg::STOP_CLOCK_REQUEST_EXIT_CYC,
   parameter int SLP_ENTER_CYC = lps_pkg::SLEEP_ENTER_CYC,
   parameter int SLP_EXIT_CYC  = lps_pkg::SLEEP_EXIT_CYC
) (
   // Clock, reset and enable.
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic              clk_en,
   // Pin requests from system logic, asynchronous, active high here.
   input  wire logic              stop_clock_request,
   input  wire logic              sleep_request,
   input  wire logic              reset_request,
   input  wire lps_pkg::lps_evt_t evt_pins,
   input  wire logic              cache_flush_request,
   input  wire logic              addr_bit20_mask,
   input  wire logic              address_strobe,
   input  wire logic              snoop_done,
   // Core-side inputs on ref_clk.
   input  wire logic              halt_exec,
   input  wire logic              smm_resume_halt,
   input  wire logic              smm_return,
   input  wire logic              cache_queues_empty,
   input  wire logic              flush_done,
   input  wire logic              cycle_done,
   input  wire logic              msr_wr,
   input  wire logic [11:0]       msr_addr,
   input  wire logic [31:0]       msr_wdata,
   // Outputs.
   output var  lps_pkg::lps_cycle_t  bus_cycle,
   output var  lps_pkg::lps_state_t  state,
   output var  logic              core_clk_stop,
   output var  logic              core_reinit,
   output var  logic              flush_start,
   output var  logic              a20_mask_active,
   output var  logic              smm_enter,
   output var  lps_pkg::lps_evt_t pending_evt,
   output var  logic              evt_service,
   output var  logic              cache_req_enable
);

   // ==========================================================================
   // Two-stage synchronisers for every pin input.
   localparam int NSYNC = 13;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;

   assign pin_raw = {stop_clock_request, sleep_request, reset_request, evt_pins,
                     cache_flush_request, addr_bit20_mask, address_strobe, snoop_done,
                     1'b0};

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (clk_en) begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   wire              stp_s   = sync2_q[12];
   wire              slp_s   = sync2_q[11];
   wire              rst_s   = sync2_q[10];
   wire lps_pkg::lps_evt_t evt_s = sync2_q[9:5];
   wire              flush_s = sync2_q[4];
   wire              a20_s   = sync2_q[3];
   wire              ads_s   = sync2_q[2];
   wire              snpd_s  = sync2_q[1];

   // ==========================================================================
   // Decode helpers.
   function automatic logic any_evt(input lps_pkg::lps_evt_t e);
      any_evt = e.smi | e.bus_init | e.warm_init | (|e.lint);
   endfunction : any_evt

   function automatic logic is_low_power(input lps_pkg::lps_state_t s);
      is_low_power = (s != lps_pkg::ST_NORMAL) && (s != lps_pkg::ST_RESUME);
   endfunction : is_low_power

   // ==========================================================================
   // State registers.
   localparam int        CNT_W_L = lps_pkg::CNT_W;
   lps_pkg::lps_state_t  st_q, st_d;
   lps_pkg::lps_state_t  ret_q, ret_d;
   logic                 from_halt_q, from_halt_d;
   logic                 clkstop_en_q;
   logic                 in_smm_q;
   logic                 flushing_q;
   logic [CNT_W_L-1:0]   cnt_q, cnt_d;
   lps_pkg::lps_evt_t    latched_q;

   wire [CNT_W_L-1:0] stp_lim  = CNT_W_L'(STP_EXIT_CYC - 1);
   wire [CNT_W_L-1:0] sin_lim  = CNT_W_L'(SLP_ENTER_CYC - 1);
   wire [CNT_W_L-1:0] sout_lim = CNT_W_L'(SLP_EXIT_CYC - 1);

   // Halt entry waits for the cache queues to drain.
   wire halt_go  = halt_exec && cache_queues_empty && !in_smm_q;          // RQ3 RQ22
   wire stop_go  = stp_s && cache_queues_empty;                           // RQ22
   wire wake_evt = any_evt(evt_s) || any_evt(latched_q);                  // RQ4
   wire in_grant = (st_q == lps_pkg::ST_GRANT);
   // Events arriving in grant or sleep transitions are held, not serviced.
   wire hold_evt = in_grant || (st_q == lps_pkg::ST_SLP_IN) || (st_q == lps_pkg::ST_SLEEP)
                   || (st_q == lps_pkg::ST_SLP_OUT) || (st_q == lps_pkg::ST_RESUME);

   // ==========================================================================
   // Next-state logic.
   always_comb begin
      st_d        = st_q;
      ret_d       = ret_q;
      from_halt_d = from_halt_q;
      cnt_d       = cnt_q;
      case (st_q)
         lps_pkg::ST_NORMAL: begin
            if (stop_go) begin
               st_d        = lps_pkg::ST_GRANT;                           // RQ9
               from_halt_d = 1'b0;
            end else if (halt_go) begin
               st_d = lps_pkg::ST_HALT;                                   // RQ3
            end
         end
         lps_pkg::ST_HALT: begin
            if (stop_go) begin
               st_d        = lps_pkg::ST_GRANT;                           // RQ8
               from_halt_d = 1'b1;
            end else if (ads_s) begin
               st_d  = lps_pkg::ST_SNOOP;                                 // RQ14
               ret_d = lps_pkg::ST_HALT;
            end else if (wake_evt) begin
               st_d = lps_pkg::ST_NORMAL;                                 // RQ4 RQ5
            end
         end
         lps_pkg::ST_GRANT: begin
            cnt_d = '0;
            if (slp_s) begin
               st_d = lps_pkg::ST_SLP_IN;                                 // RQ15 RQ17
            end else if (ads_s) begin
               st_d  = lps_pkg::ST_SNOOP;                                 // RQ14
               ret_d = lps_pkg::ST_GRANT;
            end else if (!stp_s) begin
               st_d = lps_pkg::ST_RESUME;                                 // RQ9
            end
         end
         lps_pkg::ST_SNOOP: begin
            if (snpd_s) begin
               st_d = ret_q;                                              // RQ14
            end
         end
         lps_pkg::ST_SLP_IN: begin
            cnt_d = cnt_q + CNT_W_L'(1);
            if (cnt_q >= sin_lim) begin
               st_d  = lps_pkg::ST_SLEEP;                                 // RQ16
               cnt_d = '0;
            end
         end
         lps_pkg::ST_SLEEP: begin
            cnt_d = '0;
            if (!slp_s) begin
               st_d = lps_pkg::ST_SLP_OUT;                                // RQ16
            end
         end
         lps_pkg::ST_SLP_OUT: begin
            cnt_d = cnt_q + CNT_W_L'(1);
            if (cnt_q >= sout_lim) begin
               st_d  = lps_pkg::ST_GRANT;                                 // RQ16
               cnt_d = '0;
            end
         end
         lps_pkg::ST_RESUME: begin
            cnt_d = cnt_q + CNT_W_L'(1);
            if (stp_s) begin
               st_d  = lps_pkg::ST_GRANT;
               cnt_d = '0;
            end else if (cnt_q >= stp_lim) begin
               // Released from halt: back to halt with no new halt cycle.
               st_d  = from_halt_q ? lps_pkg::ST_HALT : lps_pkg::ST_NORMAL; // RQ8 RQ9
               cnt_d = '0;
            end
         end
         default: begin
            st_d = lps_pkg::ST_NORMAL;
         end
      endcase
      // Reset pin: sleep resets straight to normal, grant stays in grant.
      if (rst_s) begin
         cnt_d = '0;
         if (in_grant) begin
            st_d = lps_pkg::ST_GRANT;                                     // RQ12
         end else begin
            st_d = lps_pkg::ST_NORMAL;                                    // RQ4 RQ20
         end
      end
   end

   // ==========================================================================
   // Special cycle selection, issued only on entry.
   wire enter_halt  = (st_q == lps_pkg::ST_NORMAL) && (st_d == lps_pkg::ST_HALT);
   wire enter_grant = (st_d == lps_pkg::ST_GRANT) && ((st_q == lps_pkg::ST_NORMAL)
                      || (st_q == lps_pkg::ST_HALT));
   lps_pkg::lps_cycle_t cyc_d;
   assign cyc_d.valid        = enter_halt || enter_grant;                 // RQ3 RQ9
   assign cyc_d.byte_enables = enter_grant ? lps_pkg::BE_STOP_GRANT
                             : enter_halt ? lps_pkg::BE_HALT : lps_pkg::BE_IDLE;
   assign cyc_d.req          = (enter_halt || enter_grant) ? lps_pkg::REQ_SPECIAL
                                                           : lps_pkg::REQ_IDLE;

   // Management interrupt taken from halt goes to normal; the handler's return does not change the state.
   wire smi_take = (st_q == lps_pkg::ST_HALT) && (evt_s.smi || latched_q.smi) && !stp_s
                   && !ads_s && !rst_s;                                   // RQ5
   // Flush only in halt; never in grant.
   wire flush_take = (st_q == lps_pkg::ST_HALT) && flush_s && !flushing_q && !stp_s; // RQ6 RQ11
   wire evt_now   = (st_q == lps_pkg::ST_NORMAL) && any_evt(latched_q);  // RQ13
   wire clk_off   = clkstop_en_q && ((st_q == lps_pkg::ST_GRANT)
                    || (st_q == lps_pkg::ST_SLEEP));                      // RQ1
   wire wr_clkstop = msr_wr && (msr_addr == lps_pkg::CLKSTOP_MSR_ADDR);

   // ==========================================================================
   // Registers.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q         <= lps_pkg::ST_NORMAL;
         ret_q        <= lps_pkg::ST_HALT;
         from_halt_q  <= 1'b0;
         cnt_q        <= '0;
         clkstop_en_q <= lps_pkg::CLKSTOP_RST;
         in_smm_q     <= 1'b0;
         flushing_q   <= 1'b0;
         latched_q    <= '0;
      end else if (clk_en) begin
         st_q        <= smi_take ? lps_pkg::ST_NORMAL : st_d;
         ret_q       <= ret_d;
         from_halt_q <= from_halt_d;
         cnt_q       <= cnt_d;
         if (wr_clkstop) begin
            clkstop_en_q <= msr_wdata[lps_pkg::CLKSTOP_BIT];              // RQ1
         end
         if (smi_take) begin
            in_smm_q <= 1'b1;
         end else if (smm_return) begin
            in_smm_q <= 1'b0;
         end
         if (flush_take) begin
            flushing_q <= 1'b1;
         end else if (flush_done) begin
            flushing_q <= 1'b0;
         end
         // Set wins over clear; sleep does not latch anything.
         if (st_q != lps_pkg::ST_SLEEP) begin
            latched_q <= (evt_now || smi_take ? '0 : latched_q)
                         | (hold_evt ? evt_s : '0);                       // RQ11 RQ13
         end
      end
   end

   // Handler return asking for halt; it only drives cache_req_enable, the state is left unchanged.
   wire smm_to_halt = smm_return && smm_resume_halt && in_smm_q;          // RQ5

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bus_cycle        <= '0;
         state            <= lps_pkg::ST_NORMAL;
         core_clk_stop    <= 1'b0;
         core_reinit      <= 1'b0;
         flush_start      <= 1'b0;
         a20_mask_active  <= 1'b0;
         smm_enter        <= 1'b0;
         pending_evt      <= '0;
         evt_service      <= 1'b0;
         cache_req_enable <= 1'b1;
      end else if (clk_en) begin
         bus_cycle        <= cyc_d;
         state            <= st_q;
         core_clk_stop    <= clk_off;
         core_reinit      <= rst_s && (st_q != lps_pkg::ST_SLEEP || !slp_s); // RQ4 RQ12 RQ20
         flush_start      <= flush_take;                                  // RQ6
         a20_mask_active  <= a20_s;                                       // RQ7
         smm_enter        <= smi_take;                                    // RQ5
         pending_evt      <= latched_q;
         evt_service      <= evt_now;                                     // RQ13
         cache_req_enable <= !is_low_power(st_q) || smm_to_halt;          // RQ22
      end
   end

endmodule : lps_ctrl

`default_nettype wire

// ---- sim/lps_ctrl_asserts.sv ----
// Port-level checks of the low-power state controller.
`timescale 1ns/1ps
`default_nettype none
module lps_ctrl_asserts #(
   parameter int STP_EXIT_CYC  = 2,
   parameter int SLP_ENTER_CYC = 2,
   parameter int SLP_EXIT_CYC  = 2
) (
   // Clock and reset.
   input wire logic                ref_clk,
   input wire logic                srst,
   // Watched outputs.
   input wire lps_pkg::lps_cycle_t bus_cycle,
   input wire lps_pkg::lps_state_t state,
   input wire logic                core_clk_stop,
   input wire logic                flush_start,
   input wire logic                evt_service,
   input wire logic                cache_req_enable
);
   // ==========================================================================
   // State decode.
   localparam int EXIT_MAX = STP_EXIT_CYC + 3;
   localparam int ENT_MAX  = SLP_ENTER_CYC + 3;
   localparam int WAK_MAX  = SLP_EXIT_CYC + 3;
   wire logic nrm = state == lps_pkg::ST_NORMAL;
   wire logic hlt = state == lps_pkg::ST_HALT;
   wire logic gnt = state == lps_pkg::ST_GRANT;
   wire logic snp = state == lps_pkg::ST_SNOOP;
   wire logic sin = state == lps_pkg::ST_SLP_IN;
   wire logic slp = state == lps_pkg::ST_SLEEP;
   wire logic sout = state == lps_pkg::ST_SLP_OUT;
   wire logic res = state == lps_pkg::ST_RESUME;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   // ==========================================================================
   // Assertions.
   AST_HALT_CYCLE: assert property (hlt && $past(nrm) |->
      $past(bus_cycle) == {1'b1, lps_pkg::BE_HALT, lps_pkg::REQ_SPECIAL})
      else $error("halt entry without halt cycle");
   AST_GRANT_CYCLE: assert property (gnt && ($past(nrm) || $past(hlt)) |->
      $past(bus_cycle.valid) && $past(bus_cycle.byte_enables) == lps_pkg::BE_STOP_GRANT)
      else $error("grant entry without grant cycle");
   AST_NO_NEW_HALT: assert property (hlt && $past(res) |-> !$past(bus_cycle.valid))
      else $error("halt cycle repeated after grant");
   AST_SLEEP_FROM_GRANT: assert property (sin && !$past(sin) |-> $past(gnt))
      else $error("sleep entry outside grant");
   AST_STOP_EXIT: assert property (res && $past(gnt) |-> ##[1:EXIT_MAX] (nrm || hlt))
      else $error("grant exit too slow");
   AST_SLEEP_ENTRY: assert property (sin && $past(gnt) |-> ##[1:ENT_MAX] slp)
      else $error("sleep entry too slow");
   AST_SLEEP_EXIT: assert property (sout && $past(slp) |-> ##[1:WAK_MAX] gnt)
      else $error("sleep exit too slow");
   AST_SNOOP_FROM: assert property (snp && !$past(snp) |-> $past(hlt) || $past(gnt))
      else $error("snoop entered from wrong state");
   AST_FLUSH_IN_HALT: assert property (flush_start |-> hlt)
      else $error("flush outside halt");
   AST_GRANT_HOLDS_EVT: assert property (gnt && $past(gnt) |-> !evt_service)
      else $error("event serviced in grant");
   AST_SLEEP_NO_CACHE: assert property (slp |-> !cache_req_enable)
      else $error("cache requests open in sleep");
   AST_CLK_STOP_LP: assert property (core_clk_stop && $past(core_clk_stop) |-> !nrm && !hlt)
      else $error("core clocks stopped while running");

   cover property (slp);
   cover property (snp ##[1:8] gnt);
   cover property (flush_start);
endmodule : lps_ctrl_asserts

bind lps_ctrl lps_ctrl_asserts #(
   .STP_EXIT_CYC (STP_EXIT_CYC),
   .SLP_ENTER_CYC(SLP_ENTER_CYC),
   .SLP_EXIT_CYC (SLP_EXIT_CYC)
) u_lps_chk (.*);
`default_nettype wire

// ---- sim/lps_sys_model.sv ----
// System core logic model that drives the stop and sleep requests.
`timescale 1ns/1ps
`default_nettype none
module lps_sys_model #(
   parameter int WAIT_CYC = 100 * lps_pkg::BCLK_PERIOD_PS / lps_pkg::CLK_PERIOD_PS
) (
   // Clock and reset.
   input  wire logic                ref_clk,
   input  wire logic                srst,
   // Commands from the bench.
   input  wire logic                want_stop,
   input  wire logic                want_sleep,
   input  wire logic                rogue_sleep,
   // Device side.
   input  wire lps_pkg::lps_cycle_t bus_cycle,
   output wire logic                stop_clock_request,
   output wire logic                sleep_request
);
   logic [8:0] wait_q;
   logic       slp_q;
   logic       stop_q;
   wire logic  grant_seen = bus_cycle.valid && bus_cycle.byte_enables == lps_pkg::BE_STOP_GRANT;

   assign sleep_request      = slp_q || rogue_sleep;
   assign stop_clock_request = stop_q;

   // The wait restarts at each grant cycle.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         {wait_q, slp_q, stop_q} <= '0;
      end else begin
         if (!stop_q || grant_seen) begin
            wait_q <= '0;
         end else if (wait_q != 9'h1FF) begin
            wait_q <= wait_q + 9'h001;
         end
         slp_q  <= want_sleep && stop_q && (slp_q || int'(wait_q) >= WAIT_CYC);
         stop_q <= want_stop || slp_q;
      end
   end
endmodule : lps_sys_model
`default_nettype wire

// ---- sim/tb_cpu_low_power_state_control.sv ----
// Self-checking bench for the low-power state controller.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_low_power_state_control;
   localparam int XC = 2;
   logic                ref_clk, srst, reset_request, cache_flush_request, addr_bit20_mask;
   logic                address_strobe, snoop_done, halt_exec, flush_done, msr_wr;
   logic                want_stop, want_sleep, rogue_sleep, smm_return;
   logic [11:0]         msr_addr;
   logic [31:0]         msr_wdata;
   lps_pkg::lps_evt_t   evt_pins;
   wire logic           stop_clock_request, sleep_request, core_clk_stop, core_reinit;
   wire logic           flush_start, a20_mask_active, smm_enter, evt_service, cache_req_enable;
   wire lps_pkg::lps_cycle_t bus_cycle;
   wire lps_pkg::lps_state_t state;
   wire lps_pkg::lps_evt_t   pending_evt;
   int                  err_total, check_count, halt_n, grant_n, flush_n, evt_n, smm_n;

   lps_ctrl #(.STP_EXIT_CYC(XC), .SLP_ENTER_CYC(XC), .SLP_EXIT_CYC(XC)) dut (.*, .clk_en(1'b1),
      .smm_resume_halt(1'b0), .cache_queues_empty(1'b1), .cycle_done(1'b0));
   lps_sys_model u_sys (.*);

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (bus_cycle === {1'b1, lps_pkg::BE_HALT, lps_pkg::REQ_SPECIAL}) halt_n++;
      if (bus_cycle.valid === 1'b1 && bus_cycle.byte_enables === lps_pkg::BE_STOP_GRANT) grant_n++;
      if (flush_start === 1'b1) flush_n++;
      if (evt_service === 1'b1) evt_n++;
      if (smm_enter === 1'b1) smm_n++;
   end

   task automatic test_done();
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic wait_st(input lps_pkg::lps_state_t s, input int lim);
      int n;
      n = 0;
      while (state !== s && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      chk("state", s, state);
      if (state !== s) test_done();
   endtask : wait_st

   task automatic go_halt();
      @(posedge ref_clk);
      halt_exec <= 1'b1;
      @(posedge ref_clk);
      halt_exec <= 1'b0;
      wait_st(lps_pkg::ST_HALT, 6);
   endtask : go_halt

   task automatic leave(input lps_pkg::lps_evt_t e);
      @(posedge ref_clk);
      evt_pins <= e;
      wait_st(lps_pkg::ST_NORMAL, 8);
      @(posedge ref_clk);
      evt_pins <= '0;
      cyc(4);
   endtask : leave

   task automatic t_halt_exit();
      int h;
      for (int i = 0; i < 5; i++) begin
         h = halt_n;
         go_halt();
         chk("halt_cycle", h + 1, halt_n);
         chk("cache_req_enable", 0, cache_req_enable);
         leave(lps_pkg::lps_evt_t'(5'h01 << i));
      end
      chk("smm_enter", 1, smm_n);
      @(posedge ref_clk);
      smm_return <= 1'b1;
      @(posedge ref_clk);
      smm_return <= 1'b0;
   endtask : t_halt_exit

   task automatic t_halt_svc();
      int f;
      f = flush_n;
      go_halt();
      @(posedge ref_clk);
      {cache_flush_request, addr_bit20_mask, rogue_sleep} <= 3'h7;
      cyc(6);
      {cache_flush_request, flush_done} <= 2'h1;
      @(posedge ref_clk);
      {flush_done, rogue_sleep} <= 2'h0;
      cyc(3);
      @(negedge ref_clk);
      chk("flush_started", 1, flush_n > f);
      chk("a20_mask_active", 1, a20_mask_active);
      chk("halt_kept", lps_pkg::ST_HALT, state);
      @(posedge ref_clk);
      addr_bit20_mask <= 1'b0;
   endtask : t_halt_svc

   task automatic t_grant_halt();
      int g, h, f;
      {g, h, f} = {grant_n, halt_n, flush_n};
      @(posedge ref_clk);
      want_stop <= 1'b1;
      wait_st(lps_pkg::ST_GRANT, 8);
      chk("grant_cycle", g + 1, grant_n);
      chk("core_clk_stop", 0, core_clk_stop);
      @(posedge ref_clk);
      {address_strobe, cache_flush_request} <= 2'h3;
      wait_st(lps_pkg::ST_SNOOP, 8);
      @(posedge ref_clk);
      {address_strobe, snoop_done} <= 2'h1;
      wait_st(lps_pkg::ST_GRANT, 8);
      @(posedge ref_clk);
      {snoop_done, cache_flush_request, want_stop} <= 3'h0;
      wait_st(lps_pkg::ST_HALT, XC + 10);
      chk("flush_ignored", f, flush_n);
      chk("halt_cycles", h, halt_n);
      leave(5'h01);
   endtask : t_grant_halt

   task automatic t_grant_reset();
      int e;
      @(posedge ref_clk);
      want_stop <= 1'b1;
      wait_st(lps_pkg::ST_GRANT, 8);
      e = evt_n;
      @(posedge ref_clk);
      reset_request <= 1'b1;
      cyc(6);
      @(negedge ref_clk);
      chk("core_reinit", 1, core_reinit);
      @(posedge ref_clk);
      reset_request <= 1'b0;
      evt_pins      <= 5'h09;
      cyc(6);
      evt_pins <= '0;
      cyc(4);
      @(negedge ref_clk);
      chk("grant_kept", lps_pkg::ST_GRANT, state);
      chk("bus_init_latched", 1, pending_evt.bus_init);
      chk("grant_service", e, evt_n);
      @(posedge ref_clk);
      want_stop <= 1'b0;
      wait_st(lps_pkg::ST_NORMAL, XC + 10);
      cyc(4);
      chk("serviced", 1, evt_n > e);
   endtask : t_grant_reset

   task automatic t_sleep();
      @(posedge ref_clk);
      rogue_sleep <= 1'b1;
      cyc(8);
      @(negedge ref_clk);
      chk("sleep_ignored", lps_pkg::ST_NORMAL, state);
      @(posedge ref_clk);
      {rogue_sleep, msr_wr, msr_addr, msr_wdata} <= {2'h1, lps_pkg::CLKSTOP_MSR_ADDR, 32'h0400_0000};
      @(posedge ref_clk);
      {msr_wr, want_stop, want_sleep} <= 3'h3;
      wait_st(lps_pkg::ST_SLEEP, 260);
      chk("core_clk_stop", 1, core_clk_stop);
      chk("cache_req_enable", 0, cache_req_enable);
      @(posedge ref_clk);
      want_sleep <= 1'b0;
      wait_st(lps_pkg::ST_GRANT, XC + 10);
      @(posedge ref_clk);
      want_sleep <= 1'b1;
      wait_st(lps_pkg::ST_SLEEP, 20);
      @(posedge ref_clk);
      reset_request <= 1'b1;
      wait_st(lps_pkg::ST_NORMAL, 8);
      @(posedge ref_clk);
      {reset_request, want_sleep, want_stop} <= 3'h0;
      cyc(8);
      wait_st(lps_pkg::ST_NORMAL, 40);
   endtask : t_sleep

   initial begin
      srst = 1'b1;
      {reset_request, cache_flush_request, addr_bit20_mask, address_strobe, snoop_done} = '0;
      {halt_exec, flush_done, msr_wr, want_stop, want_sleep, rogue_sleep, smm_return} = '0;
      {msr_addr, msr_wdata, evt_pins} = '0;
      cyc(3);
      srst <= 1'b0;
      cyc(4);
      t_halt_exit();
      t_halt_svc();
      t_grant_halt();
      t_grant_reset();
      t_sleep();
      test_done();
   end
endmodule : tb_cpu_low_power_state_control
`default_nettype wire
